// ---- include/crc_pkg.sv ----
// Constants, carriers and state layout of the programmable CRC generator
`default_nettype none
package crc_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [4:0] OFF_CONTROL    = 5'h00;
	localparam logic [4:0] OFF_TERMS      = 5'h04;
	localparam logic [4:0] OFF_INPUT      = 5'h08;
	localparam logic [4:0] OFF_RESULT     = 5'h0C;
	localparam logic [4:0] OFF_IRQ_STATUS = 5'h10;
	localparam logic [4:0] OFF_IRQ_CLEAR  = 5'h14;
	localparam logic [4:0] OFF_IRQ_ENABLE = 5'h18;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int HALT_BIT   = 13;
	localparam int COUNT_LSB  = 8;
	localparam int FULL_BIT   = 7;
	localparam int EMPTY_BIT  = 6;
	localparam int GO_BIT     = 4;
	localparam int POLY_LENGTH_MINUS_ONE_LSB   = 0;
	localparam int DONE_BIT   = 0;

	// ----------------------------------------
	// FIFO geometry and reset values
	// ----------------------------------------
	localparam logic [4:0]  DEPTH_LONG  = 5'h10;
	localparam logic [4:0]  DEPTH_SHORT = 5'h08;
	localparam logic [3:0]  POLY_LENGTH_MINUS_ONE_SPLIT  = 4'h7;
	localparam logic [3:0]  POLY_LENGTH_MINUS_ONE_RESET  = 4'h0;
	localparam logic [4:0]  COUNT_RESET = 5'h00;
	localparam logic [15:0] CRC_RESET   = 16'h0000;
	localparam logic [15:0] TERM_RESET  = 16'h0000;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} bus_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} bus_rsp_t;

	typedef struct packed {
		logic [15:0][15:0] fifo;
		logic [3:0]        wr_ptr;
		logic [3:0]        rd_ptr;
		logic [4:0]        count;
		logic [3:0]        bitpos;
		logic [15:0]       crc;
		logic [15:1]       terms;
		logic [3:0]        poly_length_minus_one;
		logic              go;
		logic              halt_in_idle;
		logic              status;
		logic              enable;
		logic              irq;
		logic              waitrequest;
		logic [31:0]       readdata;
	} crc_state_t;
endpackage
`default_nettype wire

// ---- verilog/crc_bit_step.sv ----
// One-bit step of the programmable linear feedback shift register
`default_nettype none
module crc_bit_step (
	input  wire logic [15:0] crc,      // Current remainder
	input  wire logic        bit_in,   // Incoming data bit
	input  wire logic [15:1] terms,    // Polynomial terms 15..1
	input  wire logic [3:0]  poly_length_minus_one,     // Length minus one
	output logic      [15:0] next_crc  // Remainder after this bit
);
	logic        fb;
	logic [15:0] mask;
	logic [15:0] poly;

	always_comb begin
		// Top term is implicit: the bit leaving position poly_length_minus_one is the feedback
		fb       = bit_in ^ crc[poly_length_minus_one];
		mask     = 16'hFFFF >> (4'hF - poly_length_minus_one);
		poly     = {terms, 1'b1};
		next_crc = ({crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000)) & mask;
	end
endmodule
`default_nettype wire

// ---- verilog/crc_generator.sv ----
// Programmable CRC generator with word FIFO, serial shifter and Avalon-MM registers
// What this block does
// - Length field holds polynomial length minus one
// - Term register gives terms 15..1 only
// - FIFO depth 8 above length 7, else 16
// - Write reaching data MSb increments word count
// - Shift while go and count nonzero; decrement
// - One data bit shifted per clock
// - Full at depth, empty at zero
// - Write when full wraps count, no interrupt
// - Interrupt only on count falling one to zero
// - Sleep freezes the shifter, resumes when sleep_req drops
// - Idle with halt bit behaves as Sleep
// - Go clear stops shifter; defined reset values
//
// Implementation choices: the address map and register access over Avalon-MM.
`default_nettype none
module crc_generator (
	input  wire logic              core_clk,  // 100 MHz clock
	input  wire logic              nrst,      // Async reset, active low
	input  wire crc_pkg::bus_req_t bus_req,   // Avalon-MM request
	output crc_pkg::bus_rsp_t      bus_rsp,   // Avalon-MM response
	input  wire logic              sleep_req, // Device in Sleep
	input  wire logic              idle_req,  // Device in Idle
	output logic                   irq        // Level interrupt
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	crc_pkg::crc_state_t s;
	crc_pkg::crc_state_t next_s;

	logic        acc;
	logic        req;
	logic        freeze;
	logic        active;
	logic        push;
	logic        pop;
	logic        wrap;
	logic        full;
	logic        done_evt;
	logic        msb_lane;
	logic [4:0]  depth;
	logic [2:0]  sel;
	logic [15:0] step_crc;
	logic [15:0] ctrl_view;
	logic [15:0] len_mask;

	function automatic logic [3:0] ptr_next(input logic [3:0] p, input logic [4:0] d);
		ptr_next = (p == 4'(d - 5'h01)) ? 4'h0 : p + 4'h1;
	endfunction

	crc_bit_step u_step (
		.crc      (s.crc),
		.bit_in   (s.fifo[s.rd_ptr][s.bitpos]),
		.terms    (s.terms),
		.poly_length_minus_one     (s.poly_length_minus_one),
		.next_crc (step_crc)
	);

	// ----------------------------------------
	// Decode and shifter control
	// ----------------------------------------
	always_comb begin
		req    = bus_req.read | bus_req.write;
		acc    = req & ~s.waitrequest;
		sel    = bus_req.address[4:2];
		depth  = (s.poly_length_minus_one > crc_pkg::POLY_LENGTH_MINUS_ONE_SPLIT) ? crc_pkg::DEPTH_SHORT : crc_pkg::DEPTH_LONG;
		full   = (s.count == depth);
		// Sleep, or Idle with the halt bit, suspends the shifter but not the bus
		freeze = sleep_req | (idle_req & s.halt_in_idle);
		active = s.go & (s.count != 5'h00) & ~freeze;
		pop    = active & (s.bitpos == 4'h0);
		// The word counts once the byte lane holding its MSb is written
		msb_lane = (s.poly_length_minus_one > crc_pkg::POLY_LENGTH_MINUS_ONE_SPLIT) ? bus_req.byteenable[1] : bus_req.byteenable[0];
		push   = acc & bus_req.write & (sel == crc_pkg::OFF_INPUT[4:2]) & msb_lane;
		wrap   = push & full;
		done_evt = pop & ~push & (s.count == 5'h01);
		len_mask = 16'hFFFF >> (4'hF - s.poly_length_minus_one);
		ctrl_view = 16'h0000;
		ctrl_view[crc_pkg::HALT_BIT]                     = s.halt_in_idle;
		ctrl_view[crc_pkg::COUNT_LSB +: 5]               = s.count;
		ctrl_view[crc_pkg::FULL_BIT]                     = full;
		ctrl_view[crc_pkg::EMPTY_BIT]                    = (s.count == 5'h00);
		ctrl_view[crc_pkg::GO_BIT]                       = s.go;
		ctrl_view[crc_pkg::POLY_LENGTH_MINUS_ONE_LSB +: 4]                = s.poly_length_minus_one;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;

		// Shifter: one bit per clock, MSb of each word first
		if (active) begin
			next_s.crc = step_crc;
			if (s.bitpos == 4'h0) begin
				next_s.bitpos = s.poly_length_minus_one;
				next_s.rd_ptr = ptr_next(s.rd_ptr, depth);
			end else begin
				next_s.bitpos = s.bitpos - 4'h1;
			end
		end else if (s.count == 5'h00) begin
			// Realign to the top bit so the next word starts cleanly
			next_s.bitpos = s.poly_length_minus_one;
		end

		// Word count and write side of the FIFO
		if (wrap) begin
			// Overflow discards the queue and looks empty, with no event
			next_s.count  = 5'h00;
			next_s.wr_ptr = 4'h0;
			next_s.rd_ptr = 4'h0;
			next_s.bitpos = s.poly_length_minus_one;
		end else begin
			if (push) begin
				next_s.fifo[s.wr_ptr] = bus_req.writedata[15:0];
				next_s.wr_ptr         = ptr_next(s.wr_ptr, depth);
			end
			next_s.count = s.count + {4'h0, push} - {4'h0, pop};
		end

		// Register writes
		if (acc && bus_req.write) begin
			case (sel)
				crc_pkg::OFF_CONTROL[4:2]: begin
					if (bus_req.byteenable[0]) begin
						next_s.go   = bus_req.writedata[crc_pkg::GO_BIT];
						next_s.poly_length_minus_one = bus_req.writedata[crc_pkg::POLY_LENGTH_MINUS_ONE_LSB +: 4];
					end
					if (bus_req.byteenable[1]) begin
						next_s.halt_in_idle = bus_req.writedata[crc_pkg::HALT_BIT];
					end
				end
				crc_pkg::OFF_TERMS[4:2]: begin
					if (bus_req.byteenable[0]) begin
						next_s.terms[7:1] = bus_req.writedata[7:1];
					end
					if (bus_req.byteenable[1]) begin
						next_s.terms[15:8] = bus_req.writedata[15:8];
					end
				end
				crc_pkg::OFF_RESULT[4:2]: begin
					// Preset of the remainder; a bus write beats a shift in the same cycle
					next_s.crc = bus_req.writedata[15:0] & len_mask;
				end
				crc_pkg::OFF_IRQ_ENABLE[4:2]: begin
					if (bus_req.byteenable[0]) begin
						next_s.enable = bus_req.writedata[crc_pkg::DONE_BIT];
					end
				end
				default: begin
				end
			endcase
		end

		// Sticky status: a new event wins over a clear in the same cycle
		if (acc && bus_req.write && sel == crc_pkg::OFF_IRQ_CLEAR[4:2] && bus_req.byteenable[0]
				&& bus_req.writedata[crc_pkg::DONE_BIT]) begin
			next_s.status = 1'b0;
		end
		if (done_evt) begin
			next_s.status = 1'b1;
		end
		// Interrupt keeps flowing while frozen so pending events still reach the CPU
		next_s.irq = next_s.status & next_s.enable;

		// Bus handshake: one wait cycle, then the access completes
		next_s.waitrequest = ~(req & s.waitrequest);
		next_s.readdata    = 32'h0000_0000;
		if (req && s.waitrequest && bus_req.read) begin
			case (sel)
				crc_pkg::OFF_CONTROL[4:2]:    next_s.readdata = {16'h0000, ctrl_view};
				crc_pkg::OFF_TERMS[4:2]:      next_s.readdata = {16'h0000, s.terms, 1'b0};
				crc_pkg::OFF_RESULT[4:2]:     next_s.readdata = {16'h0000, s.crc};
				crc_pkg::OFF_IRQ_STATUS[4:2]: next_s.readdata = {31'h0000_0000, s.status};
				crc_pkg::OFF_IRQ_ENABLE[4:2]: next_s.readdata = {31'h0000_0000, s.enable};
				default:                      next_s.readdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s              <= '0;
			s.count        <= crc_pkg::COUNT_RESET;
			s.poly_length_minus_one         <= crc_pkg::POLY_LENGTH_MINUS_ONE_RESET;
			s.crc          <= crc_pkg::CRC_RESET;
			s.terms        <= crc_pkg::TERM_RESET[15:1];
			s.waitrequest  <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign bus_rsp.readdata    = s.readdata;
	assign bus_rsp.waitrequest = s.waitrequest;
	assign irq                 = s.irq;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_last_word_out;
		(s.count == 5'h01) && pop && !push;
	endsequence

	property p_depth_bound;
		s.count <= depth;
	endproperty
	a_depth_bound: assert property (p_depth_bound) else $error("word count above FIFO depth");

	property p_push_count;
		push && !full && !pop |=> s.count == $past(s.count) + 5'h01;
	endproperty
	a_push_count: assert property (p_push_count) else $error("push did not add one word");

	property p_stopped_holds;
		!s.go && !push |=> s.count == $past(s.count);
	endproperty
	a_stopped_holds: assert property (p_stopped_holds) else $error("count moved with go clear");

	property p_bit_per_clock;
		active && s.bitpos != 4'h0 |=> s.bitpos == $past(s.bitpos) - 4'h1;
	endproperty
	a_bit_per_clock: assert property (p_bit_per_clock) else $error("shifter did not take one bit");

	property p_full_flag;
		s.count == depth |-> ctrl_view[crc_pkg::FULL_BIT] && !ctrl_view[crc_pkg::EMPTY_BIT];
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("full flag wrong at depth");

	property p_wrap_silent;
		wrap && !s.status |=> s.count == 5'h00 && !s.status;
	endproperty
	a_wrap_silent: assert property (p_wrap_silent) else $error("overflow write not wrapped silently");

	property p_done_event;
		s_last_word_out |=> s.status ##1 (s.irq == s.enable);
	endproperty
	a_done_event: assert property (p_done_event) else $error("no event on last word out");

	property p_event_only_at_zero;
		$rose(s.status) |-> s.count == 5'h00 && $past(s.count) == 5'h01;
	endproperty
	a_event_only_at_zero: assert property (p_event_only_at_zero) else $error("event without fall to zero");

	property p_frozen;
		freeze && !acc |=> s.crc == $past(s.crc) && s.bitpos == $past(s.bitpos);
	endproperty
	a_frozen: assert property (p_frozen) else $error("shifter moved while frozen");

	property p_answer;
		req && s.waitrequest |=> !s.waitrequest ##1 s.waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer not one cycle");

	// ----------------------------------------
	// Word boundaries and remainder width
	// ----------------------------------------
	sequence s_word_boundary;
		active && (s.bitpos == 4'h0);
	endsequence

	property p_word_reload;
		s_word_boundary |=> s.bitpos == $past(s.poly_length_minus_one);
	endproperty
	a_word_reload: assert property (p_word_reload) else $error("bit index not reloaded after a word");

	property p_len_mask;
		active && !acc |=> (s.crc & ~len_mask) == 16'h0000;
	endproperty
	a_len_mask: assert property (p_len_mask) else $error("remainder wider than the polynomial");

	property p_pop_count;
		pop && !push |=> s.count == $past(s.count) - 5'h01;
	endproperty
	a_pop_count: assert property (p_pop_count) else $error("last bit out did not drop the count");

	property p_stop_at_zero;
		s.count == 5'h00 && !push |=> s.count == 5'h00;
	endproperty
	a_stop_at_zero: assert property (p_stop_at_zero) else $error("shifter ran past an empty queue");

	property p_wrap_clears;
		wrap |=> s.count == 5'h00 && s.wr_ptr == 4'h0 && s.rd_ptr == 4'h0;
	endproperty
	a_wrap_clears: assert property (p_wrap_clears) else $error("overflow did not empty the queue");

	property p_no_stray_event;
		!done_evt |=> !$rose(s.status);
	endproperty
	a_no_stray_event: assert property (p_no_stray_event) else $error("event without last word out");

	property p_go_off;
		!s.go && !acc |=> s.crc == $past(s.crc);
	endproperty
	a_go_off: assert property (p_go_off) else $error("remainder moved with go clear");
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench of the programmable CRC generator
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic              core_clk  = 1'b0;
	logic              nrst      = 1'b0;
	logic              sleep_req = 1'b0;
	logic              idle_req  = 1'b0;
	logic              irq;
	crc_pkg::bus_req_t req       = '0;
	crc_pkg::bus_rsp_t rsp;
	int                bad_count = 0;
	int                compares  = 0;
	logic [31:0]       rd;

	always #5 core_clk = ~core_clk;

	crc_generator dut_u (.core_clk(core_clk), .nrst(nrst), .bus_req(req), .bus_rsp(rsp),
		.sleep_req(sleep_req), .idle_req(idle_req), .irq(irq));

	// ----------------------------------------
	// Bus access and comparison
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected 0x%h seen 0x%h", what, exp, got);
		end
	endtask

	// Request held until waitrequest is sampled low; one idle edge after so strobes never re-rise in one step
	task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d, input logic [3:0] be);
		req.write      <= wr;
		req.read       <= ~wr;
		req.address    <= a;
		req.writedata  <= {16'h0000, d};
		req.byteenable <= be;
		do @(posedge core_clk); while (rsp.waitrequest !== 1'b0);
		rd = rsp.readdata;
		req.write <= 1'b0;
		req.read  <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		bus(1'b1, a, d, 4'h3);
	endtask

	task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 16'h0000, 4'h0);
		chk(what, exp, rd);
	endtask

	task automatic wait_empty;
		int n;
		n = 0;
		do begin
			bus(1'b0, crc_pkg::OFF_CONTROL, 16'h0000, 4'h0);
			n++;
		end while (rd[crc_pkg::EMPTY_BIT] !== 1'b1 && n < 200);
	endtask

	// Independent bit-serial reference, MSb first
	function automatic logic [15:0] crc_ref(input logic [15:0] w, input logic [15:0] t, input int p,
			input logic [15:0] c0);
		logic [15:0] c;
		logic        fb;
		c = c0;
		for (int i = p; i >= 0; i--) begin
			fb = w[i] ^ c[p];
			c  = c << 1;
			if (fb) begin
				c = c ^ {t[15:1], 1'b1};
			end
		end
		return c & 16'((17'h1 << (p + 1)) - 1);
	endfunction

	task automatic tally_and_finish;
		$display("mismatches %0d of %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		int          p;
		int          d;
		logic [15:0] t;
		logic [15:0] w;
		logic [15:0] c;
		logic [3:0]  be;
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rdchk("control reset", crc_pkg::OFF_CONTROL, 32'h00000040);
		rdchk("terms reset", crc_pkg::OFF_TERMS, 32'h00000000);
		rdchk("unmapped", 5'h1C, 32'h00000000);
		wr(crc_pkg::OFF_IRQ_ENABLE, 16'h0001);
		rdchk("enable", crc_pkg::OFF_IRQ_ENABLE, 32'h00000001);
		for (int k = 0; k < 2; k++) begin
			p  = k ? 15 : 7;
			t  = k ? 16'h1020 : 16'h0006;
			w  = k ? 16'h1234 : 16'h00A5;
			be = k ? 4'h3 : 4'h1;
			wr(crc_pkg::OFF_CONTROL, 16'(p));
			wr(crc_pkg::OFF_TERMS, t);
			wr(crc_pkg::OFF_RESULT, 16'h0000);
			bus(1'b1, crc_pkg::OFF_INPUT, w, be);
			rdchk("count one", crc_pkg::OFF_CONTROL, 32'h100 | 32'(p));
			wr(crc_pkg::OFF_CONTROL, 16'h0010 | 16'(p));
			rdchk("still shifting", crc_pkg::OFF_CONTROL, 32'h110 | 32'(p));
			repeat (p + 1) @(posedge core_clk);
			rdchk("done in time", crc_pkg::OFF_CONTROL, 32'h50 | 32'(p));
			rdchk("result", crc_pkg::OFF_RESULT, {16'h0000, crc_ref(w, t, p, 16'h0000)});
			chk("irq raised", 32'h1, {31'h0, irq});
			rdchk("status set", crc_pkg::OFF_IRQ_STATUS, 32'h1);
			wr(crc_pkg::OFF_IRQ_CLEAR, 16'h0001);
			rdchk("status clear", crc_pkg::OFF_IRQ_STATUS, 32'h0);
			chk("irq low", 32'h0, {31'h0, irq});
		end
		// Continuous feed: prime two words, start, then top up while below depth
		wr(crc_pkg::OFF_CONTROL, 16'h000F);
		wr(crc_pkg::OFF_RESULT, 16'h0000);
		c = 16'h0000;
		for (int i = 0; i < 5; i++) begin
			w = 16'hC0DE ^ 16'(i * 16'h1111);
			c = crc_ref(w, 16'h1020, 15, c);
			if (i >= 2) begin
				do begin
					bus(1'b0, crc_pkg::OFF_CONTROL, 16'h0000, 4'h0);
				end while (rd[crc_pkg::COUNT_LSB +: 5] >= 5'h08);
			end
			bus(1'b1, crc_pkg::OFF_INPUT, w, 4'h3);
			if (i == 1) begin
				wr(crc_pkg::OFF_CONTROL, 16'h001F);
			end
		end
		wait_empty;
		rdchk("fed result", crc_pkg::OFF_RESULT, {16'h0000, c});
		rdchk("fed event", crc_pkg::OFF_IRQ_STATUS, 32'h1);
		chk("fed irq", 32'h1, {31'h0, irq});
		wr(crc_pkg::OFF_IRQ_CLEAR, 16'h0001);
		for (int k = 0; k < 2; k++) begin
			p  = k ? 15 : 7;
			d  = k ? 8 : 16;
			be = k ? 4'h3 : 4'h1;
			wr(crc_pkg::OFF_CONTROL, 16'(p));
			for (int i = 0; i < d; i++) begin
				bus(1'b1, crc_pkg::OFF_INPUT, 16'(i), be);
			end
			rdchk("full", crc_pkg::OFF_CONTROL, 32'(d << 8) | 32'h80 | 32'(p));
			bus(1'b1, crc_pkg::OFF_INPUT, 16'h00FF, be);
			rdchk("wrap", crc_pkg::OFF_CONTROL, 32'h40 | 32'(p));
			rdchk("no event", crc_pkg::OFF_IRQ_STATUS, 32'h0);
		end
		bus(1'b1, crc_pkg::OFF_INPUT, 16'h00FF, 4'h1);
		rdchk("low lane only", crc_pkg::OFF_CONTROL, 32'h4F);
		wr(crc_pkg::OFF_IRQ_ENABLE, 16'h0000);
		// Sleep, idle with halt, idle without halt
		for (int m = 0; m < 3; m++) begin
			t = (m == 1) ? 16'h2007 : 16'h0007;
			wr(crc_pkg::OFF_CONTROL, t);
			bus(1'b1, crc_pkg::OFF_INPUT, 16'h003C, 4'h1);
			sleep_req <= (m == 0);
			idle_req  <= (m != 0);
			wr(crc_pkg::OFF_CONTROL, t | 16'h0010);
			repeat (20) @(posedge core_clk);
			rdchk("power hold", crc_pkg::OFF_CONTROL, (m == 2) ? 32'h57 : 32'(t) | 32'h110);
			sleep_req <= 1'b0;
			idle_req  <= 1'b0;
			wait_empty;
			rdchk("resumed", crc_pkg::OFF_CONTROL, 32'(t) | 32'h50);
			rdchk("status", crc_pkg::OFF_IRQ_STATUS, 32'h1);
			chk("masked irq", 32'h0, {31'h0, irq});
			wr(crc_pkg::OFF_IRQ_CLEAR, 16'h0001);
		end
		wr(crc_pkg::OFF_CONTROL, 16'h0007);
		bus(1'b1, crc_pkg::OFF_INPUT, 16'h0001, 4'h1);
		repeat (20) @(posedge core_clk);
		rdchk("go off", crc_pkg::OFF_CONTROL, 32'h107);
		// Reset with go clear and a word queued must drop the queued word and the programmed terms
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		rdchk("control after reset", crc_pkg::OFF_CONTROL, 32'h00000040);
		rdchk("terms after reset", crc_pkg::OFF_TERMS, 32'h00000000);
		tally_and_finish;
	end

	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
